// File: design/ces_top.sv
// CAN error state, FIFO pending and filter control register block on APB
//
// Contract
// - Bus-off flag high when transmit error count is 256 or more.
// - Transmit bus-passive flag high when transmit count is 128 or more.
// - Receive bus-passive flag high when receive count is 128 or more.
// - Transmit warning flag high only for transmit count 96 to 127.
// - Receive warning flag high only for receive count 96 to 127.
// - Combined warning flag is the OR of both warning flags.
// - Error count register: transmit count bits 15-8, receive count 7-0.
// - Bits 31-22 of the error count register read zero, ignore writes.
// - 32 read-only pending bits, one per FIFO, set while interrupts pending.
// - Each filter has an enable bit at bit 7 of its control byte.
// - Each filter has a 2-bit selector choosing acceptance mask 0 to 3.
// - Each filter has a 5-bit selector naming destination FIFO 0 to 31.
// - Filter fields change only while the filter's enable bit is zero.
`timescale 1ns/10ps
`default_nettype none
`include "ces_defines.svh"

module ces_top #(
  parameter int ADDR_W  = 12,
  parameter int NUM_FLT = 4
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Protocol engine counters and FIFO status
  input  wire logic [8:0]           transmit_error_count,
  input  wire logic [7:0]           receive_error_count,
  input  wire logic [31:0]          fifo_irq_raw,
  // Results toward the protocol engine
  output ces_pkg::ces_err_flags_t   err_flags,
  output ces_pkg::ces_filter_cfg_t  filter_cfg [NUM_FLT],
  // Interrupt
  output logic                      irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  ces_pkg::ces_err_flags_t err_flags_next;
  logic [7:0]              tx_cnt_reg;
  logic [7:0]              rx_cnt_reg;
  logic [31:0]             fifo_irq_pending;
  logic [`CES_IRQ_WIDTH-1:0] irq_stat_reg;
  logic [`CES_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [`CES_IRQ_WIDTH-1:0] irq_event;
  logic                    setup_phase;
  logic                    wr_fire;
  logic [31:0]             rd_next;
  logic                    err_next;
  logic [31:0]             filter_word;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, `CES_OFF_ERR_COUNT) || hit(a, `CES_OFF_FIFO_PEND)
             || hit(a, `CES_OFF_FLT_CTRL1) || hit(a, `CES_OFF_IRQ_STAT)
             || hit(a, `CES_OFF_IRQ_MASK);
  endfunction : mapped

  assign setup_phase = psel && !penable;
  assign wr_fire     = psel && penable && pready && pwrite && !pslverr;

  // ----------------------------------------
  // Counter capture and error flags
  // ----------------------------------------
  ces_err_state u_err_state (
    .transmit_error_count (transmit_error_count),
    .receive_error_count  (receive_error_count),
    .flags                (err_flags_next)
  );

  // Counts and flags sampled together so a read sees one coherent state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_cnt_reg <= 8'h00;
      rx_cnt_reg <= 8'h00;
      err_flags  <= ces_pkg::ces_err_flags_t'(6'h00);
    end
    else
    begin
      // Bit 8 shows only as the bus-off flag
      tx_cnt_reg <= transmit_error_count[7:0];
      rx_cnt_reg <= receive_error_count;
      err_flags  <= err_flags_next;
    end
  end

  // ----------------------------------------
  // FIFO pending bits
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fifo_irq_pending <= `CES_RST_WORD;
    else
      fifo_irq_pending <= fifo_irq_raw;
  end

  // ----------------------------------------
  // Filter control bytes
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_FLT; g++)
    begin : g_flt
      ces_filter_slot u_slot (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_fire && hit(paddr, `CES_OFF_FLT_CTRL1) && pstrb[g]),
        .wr_byte (pwdata[8*g +: 8]),
        .cfg     (filter_cfg[g])
      );
      assign filter_word[8*g +: 8] = filter_cfg[g];
    end
  endgenerate

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  // Rising edges only: a counter parked past a limit raises one event
  assign irq_event = {|(fifo_irq_raw & ~fifo_irq_pending),
                      err_flags_next & ~err_flags};

  // Hardware set wins over a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_reg <= `CES_RST_IRQ;
    else if (wr_fire && hit(paddr, `CES_OFF_IRQ_STAT) && pstrb[0])
      irq_stat_reg <= (irq_stat_reg & ~pwdata[`CES_IRQ_WIDTH-1:0]) | irq_event;
    else
      irq_stat_reg <= irq_stat_reg | irq_event;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_reg <= `CES_RST_IRQ;
    else if (wr_fire && hit(paddr, `CES_OFF_IRQ_MASK) && pstrb[0])
      irq_mask_reg <= pwdata[`CES_IRQ_WIDTH-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    rd_next  = `CES_RST_WORD;
    err_next = !mapped(paddr);
    if (hit(paddr, `CES_OFF_ERR_COUNT))
    begin
      // Upper bits stay zero; writes to this word are dropped
      rd_next[`CES_FLAG_MSB:`CES_FLAG_LSB]   = err_flags;
      rd_next[`CES_TXCNT_MSB:`CES_TXCNT_LSB] = tx_cnt_reg;
      rd_next[`CES_RXCNT_MSB:`CES_RXCNT_LSB] = rx_cnt_reg;
    end
    else if (hit(paddr, `CES_OFF_FIFO_PEND))
      rd_next = fifo_irq_pending;
    else if (hit(paddr, `CES_OFF_FLT_CTRL1))
      rd_next = filter_word;
    else if (hit(paddr, `CES_OFF_IRQ_STAT))
      rd_next[`CES_IRQ_WIDTH-1:0] = irq_stat_reg;
    else if (hit(paddr, `CES_OFF_IRQ_MASK))
      rd_next[`CES_IRQ_WIDTH-1:0] = irq_mask_reg;
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answer is prepared in the setup cycle so every output is a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `CES_RST_WORD;
    end
    else if (setup_phase)
    begin
      pready  <= 1'b1;
      pslverr <= err_next;
      prdata  <= pwrite ? `CES_RST_WORD : rd_next;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `CES_RST_WORD;
    end
  end

endmodule : ces_top
`default_nettype wire

// File: design/ces_defines.svh
// Offsets, field positions, limits and reset values of the CAN error status block
`ifndef CES_DEFINES_SVH
`define CES_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define CES_OFF_ERR_COUNT   12'h000
`define CES_OFF_FIFO_PEND   12'h004
`define CES_OFF_FLT_CTRL1   12'h008
`define CES_OFF_IRQ_STAT    12'h00C
`define CES_OFF_IRQ_MASK    12'h010

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CES_FLAG_LSB        16
`define CES_FLAG_MSB        21
`define CES_TXCNT_LSB       8
`define CES_TXCNT_MSB       15
`define CES_RXCNT_LSB       0
`define CES_RXCNT_MSB       7
`define CES_IRQ_FIFO_BIT    6
`define CES_IRQ_WIDTH       7

// ----------------------------------------
// Error state limits
// ----------------------------------------
`define CES_BUS_OFF_LIMIT   9'h100
`define CES_PASSIVE_LIMIT   9'h080
`define CES_WARN_LIMIT      9'h060

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CES_RST_WORD        32'h0000_0000
`define CES_RST_IRQ         7'h00
`define CES_RST_FILTER      8'h00

`endif

// File: design/ces_pkg.sv
// Types shared by the CAN error status block
`default_nettype none
package ces_pkg;

  // ----------------------------------------
  // Error state flags, in register bit order
  // ----------------------------------------
  typedef struct packed {
    logic tx_bus_off_flag;
    logic tx_bus_passive_flag;
    logic rx_bus_passive_flag;
    logic tx_warning_flag;
    logic rx_warning_flag;
    logic any_warning_flag;
  } ces_err_flags_t;

  // ----------------------------------------
  // One acceptance filter control byte
  // ----------------------------------------
  typedef struct packed {
    logic       enable;
    logic [1:0] mask_select;
    logic [4:0] fifo_select;
  } ces_filter_cfg_t;

endpackage : ces_pkg
`default_nettype wire

// File: design/ces_err_state.sv
// Error state flag derivation from the two error counters
`timescale 1ns/10ps
`default_nettype none
`include "ces_defines.svh"

module ces_err_state (
  // Counters
  input  wire logic [8:0]          transmit_error_count,
  input  wire logic [7:0]          receive_error_count,
  // Flags
  output ces_pkg::ces_err_flags_t  flags
);

  logic [8:0] rx_wide;

  assign rx_wide = {1'b0, receive_error_count};

  always_comb
  begin
    flags.tx_bus_off_flag     = transmit_error_count >= `CES_BUS_OFF_LIMIT;
    flags.tx_bus_passive_flag = transmit_error_count >= `CES_PASSIVE_LIMIT;
    flags.rx_bus_passive_flag = rx_wide >= `CES_PASSIVE_LIMIT;
    flags.tx_warning_flag     = (transmit_error_count >= `CES_WARN_LIMIT)
                                && (transmit_error_count < `CES_PASSIVE_LIMIT);
    flags.rx_warning_flag     = (rx_wide >= `CES_WARN_LIMIT)
                                && (rx_wide < `CES_PASSIVE_LIMIT);
    flags.any_warning_flag    = flags.tx_warning_flag
                                || flags.rx_warning_flag;
  end

endmodule : ces_err_state
`default_nettype wire

// File: design/ces_filter_slot.sv
// One acceptance filter control byte with its reconfiguration lock
`timescale 1ns/10ps
`default_nettype none
`include "ces_defines.svh"

module ces_filter_slot (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Byte write
  input  wire logic                 wr_en,
  input  wire logic [7:0]           wr_byte,
  // Filter setting
  output ces_pkg::ces_filter_cfg_t  cfg
);

  ces_pkg::ces_filter_cfg_t wr_cfg;

  assign wr_cfg = ces_pkg::ces_filter_cfg_t'(wr_byte);

  // Enabled filter keeps its fields; only the enable may be dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg <= ces_pkg::ces_filter_cfg_t'(`CES_RST_FILTER);
    else if (wr_en && !cfg.enable)
      cfg <= wr_cfg;
    else if (wr_en)
      cfg.enable <= wr_cfg.enable;
  end

endmodule : ces_filter_slot
`default_nettype wire

// File: verif/ces_engine_model.sv
// Behavioural protocol engine driving error counts and FIFO pending levels
`timescale 1ns/10ps
`default_nettype none
module ces_engine_model (
  // Clock
  input  wire logic   pclk,
  // Engine levels, same clock as the block
  output logic [8:0]  transmit_error_count,
  output logic [7:0]  receive_error_count,
  output logic [31:0] fifo_irq_raw
);
  initial
  begin
    transmit_error_count = 9'h000;
    receive_error_count  = 8'h00;
    fifo_irq_raw         = 32'h0000_0000;
  end
  // Levels change on a rising edge, as the engine's own flops would drive them
  task automatic load(input logic [8:0] t, input logic [7:0] r, input logic [31:0] f);
    @(posedge pclk);
    transmit_error_count <= t;
    receive_error_count  <= r;
    fifo_irq_raw         <= f;
  endtask : load
endmodule : ces_engine_model
`default_nettype wire

// File: verif/ces_top_sva.sv
// Port-level assertions for the CAN error status block
`timescale 1ns/10ps
`default_nettype none
module ces_top_sva #(
  parameter int ADDR_W  = 12,
  parameter int NUM_FLT = 4
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ADDR_W-1:0]        paddr,
  input  wire logic [31:0]              prdata,
  input  wire logic                     pready,
  input  wire logic                     pslverr,
  // Engine side
  input  wire logic [8:0]               transmit_error_count,
  input  wire logic [7:0]               receive_error_count,
  input  wire logic [31:0]              fifo_irq_raw,
  input  wire ces_pkg::ces_err_flags_t  err_flags,
  input  wire ces_pkg::ces_filter_cfg_t filter_cfg [NUM_FLT],
  input  wire logic                     irq
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sampled reset high at the launch edge, so the capture flop is already running
  property p_bus_off;
    presetn |=> err_flags.tx_bus_off_flag == ($past(transmit_error_count) >= 9'h100);
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("tx bus off flag");
  property p_tx_pass;
    presetn |=> err_flags.tx_bus_passive_flag == ($past(transmit_error_count) >= 9'h080);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx passive flag");
  property p_rx_pass;
    presetn |=> err_flags.rx_bus_passive_flag == ($past(receive_error_count) >= 8'h80);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx passive flag");
  property p_tx_warn;
    presetn |=>
      err_flags.tx_warning_flag == ($past(transmit_error_count) inside {[9'h060:9'h07F]});
  endproperty
  a_tx_warn: assert property (p_tx_warn) else $error("tx warning flag");
  property p_rx_warn;
    presetn |=>
      err_flags.rx_warning_flag == ($past(receive_error_count) inside {[8'h60:8'h7F]});
  endproperty
  a_rx_warn: assert property (p_rx_warn) else $error("rx warning flag");
  property p_any_warn;
    err_flags.any_warning_flag == (err_flags.tx_warning_flag | err_flags.rx_warning_flag);
  endproperty
  a_any_warn: assert property (p_any_warn) else $error("combined warning");
  property p_cnt_read;
    psel && penable && pready && !pwrite && paddr == 12'h000 |->
      prdata[31:22] == 10'h000 && prdata[15:8] == $past(transmit_error_count[7:0], 2)
      && prdata[7:0] == $past(receive_error_count, 2);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("count word");
  property p_fifo_read;
    psel && penable && pready && !pwrite && paddr == 12'h004 |->
      prdata == $past(fifo_irq_raw, 2);
  endproperty
  a_fifo_read: assert property (p_fifo_read) else $error("fifo pending word");
  property p_lock;
    $past(presetn) && $past(filter_cfg[0].enable) |->
      $stable(filter_cfg[0].mask_select) && $stable(filter_cfg[0].fifo_select);
  endproperty
  a_lock: assert property (p_lock) else $error("locked filter changed");
  c_bus_off: cover property (err_flags.tx_bus_off_flag);
  c_irq: cover property (irq);
  c_slverr: cover property (pready && pslverr);
endmodule : ces_top_sva
bind ces_top ces_top_sva #(.ADDR_W(ADDR_W), .NUM_FLT(NUM_FLT)) i_ces_top_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .transmit_error_count(transmit_error_count), .receive_error_count(receive_error_count),
  .fifo_irq_raw(fifo_irq_raw),
  .err_flags(err_flags), .filter_cfg(filter_cfg), .irq(irq));
`default_nettype wire

// File: verif/ces_top_tb_top.sv
// Self-checking bench for the CAN error status block
`timescale 1ns/10ps
`default_nettype none
module ces_top_tb_top;
  logic                     pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic                     pwrite = 1'b0, pready, pslverr, irq, se;
  logic [11:0]              paddr = 12'h000;
  logic [3:0]               pstrb = 4'hF;
  logic [31:0]              pwdata = 32'h0000_0000, prdata, rd, fraw;
  logic [8:0]               tec;
  logic [7:0]               rec;
  ces_pkg::ces_err_flags_t  flg;
  ces_pkg::ces_filter_cfg_t fcfg [4];
  logic [8:0]               tv [6] = '{9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
  logic [7:0]               rv [6] = '{8'h60, 8'h5F, 8'h80, 8'h7F, 8'h00, 8'hFF};
  int                       err_total = 0, comparisons = 0;
  ces_top #(.ADDR_W(12), .NUM_FLT(4)) i_ces_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .transmit_error_count(tec), .receive_error_count(rec), .fifo_irq_raw(fraw),
    .err_flags(flg), .filter_cfg(fcfg), .irq(irq));
  ces_engine_model i_ces_engine_model (.pclk(pclk), .transmit_error_count(tec),
    .receive_error_count(rec), .fifo_irq_raw(fraw));
  initial
    forever #12.5 pclk = ~pclk;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One APB transfer, then an idle cycle so psel is never driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready === 1'b1)
      @(posedge pclk);
    else
    begin
      err_total++;
      report_and_stop();
    end
  endtask : apb
  function automatic logic [31:0] exp_cnt(input logic [8:0] t, input logic [7:0] r);
    logic tw, rw;
    tw = t >= 9'h060 && t < 9'h080;
    rw = r >= 8'h60 && r < 8'h80;
    return {10'h000, t >= 9'h100, t >= 9'h080, r >= 8'h80, tw, rw, tw | rw, t[7:0], r};
  endfunction : exp_cnt
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("mask reset", 32'h0000_0000, rd);
    for (int i = 0; i < 6; i++)
    begin
      i_ces_engine_model.load(tv[i], rv[i], 32'h0000_0000);
      repeat (2) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk("count word", exp_cnt(tv[i], rv[i]), rd);
    end
    apb(1'b1, 12'h000, 32'hFFFF_FFFF);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("count after write", exp_cnt(9'h100, 8'hFF), rd);
    i_ces_engine_model.load(9'h000, 8'h00, 32'h8000_0001);
    repeat (2) @(posedge pclk);
    apb(1'b1, 12'h004, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("fifo pending", 32'h8000_0001, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("irq status", 32'h0000_007F, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h010, 32'h0000_007F);
    repeat (2) @(posedge pclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00C, 32'h0000_007F);
    apb(1'b1, 12'h010, 32'h0000_0002);
    i_ces_engine_model.load(9'h064, 8'h00, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("irq status 2", 32'h0000_0005, rd);
    chk("irq masked 2", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h010, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("irq raised 2", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h00C, 32'h0000_0005);
    repeat (2) @(posedge pclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("unmapped err", 32'h1, {31'h0, se});
    chk("unmapped data", 32'h0000_0000, rd);
    apb(1'b1, 12'h008, 32'h3A45_807F);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("filter word", 32'h3A45_807F, rd);
    chk("filter 0 out", 32'h0000_007F, {24'h0, fcfg[0]});
    apb(1'b1, 12'h008, 32'h3A45_80FF);
    apb(1'b1, 12'h008, 32'h3A45_9F80);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("locked filters", 32'h3A45_80FF, rd);
    apb(1'b1, 12'h008, 32'h3A45_9F00);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("disabled filter", 32'h3A45_807F, rd);
    // Only byte 1 strobed: filter 1 drops its enable, the others keep theirs
    pstrb <= 4'h2;
    apb(1'b1, 12'h008, 32'h0000_0000);
    pstrb <= 4'hF;
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("strobed filter byte", 32'h3A45_007F, rd);
    // Mid-run reset; the transmit count still in the warning band raises fresh events
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk("filter after reset", 32'h0000_0000, rd);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    chk("status after reset", 32'h0000_0005, rd);
    report_and_stop();
  end
endmodule : ces_top_tb_top
`default_nettype wire
